// ===== ir_carrier_pwm_timer.sv
// Purpose: IR carrier PWM timer with envelope timer and APB registers.
// Assumes: APB master per AMBA; pready is always high; sys_clk 100 MHz.
// Notes:   Counter and envelope ticks are one-cycle enables on sys_clk.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ir_carrier_pwm_timer
  import ir_carrier_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irTransmitPin,
  output logic      [1:0]        irDriveCurrent,
  output logic                   carrierOverflowEvent,
  output logic                   envelopeOverflowEvent
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  carrier_ctrl_s              ctrl_reg;
  logic                       ctrlSpare_reg;
  logic [7:0]                 periodPreload_reg;
  logic [7:0]                 highWidthPreload_reg;
  logic [7:0]                 envCtrl_reg;
  logic [ENV_WIDTH-1:0]       envPreload_reg;
  logic [7:0]                 irCtrl_reg;
  logic                       carrierFlag_reg;
  logic                       envFlag_reg;
  logic [7:0]                 counter_reg;
  logic [7:0]                 compare_reg;
  logic                       carrier_reg;
  logic                       running_reg;
  logic [ENV_WIDTH-1:0]       envCount_reg;
  logic                       envRunning_reg;
  logic                       envGate_reg;
  logic                       carrierPrev_reg;
  logic [31:0]                prdata_next;
  logic                       wrEn;
  logic                       rdEn;
  logic                       addrHit;
  logic [7:0]                 regIndex;
  logic                       carrierTick;
  logic                       envelopeTick;
  logic                       carrierOverflow;
  logic                       envStep;
  logic                       envOverflow;
  logic                       envByCarrier;
  logic                       gateOn;
  logic                       pin_next;

  assign regIndex = paddr[ADDR_W-1:2];
  assign wrEn     = psel && penable && pwrite;
  assign rdEn     = psel && !penable && !pwrite;
  assign addrHit  = (regIndex == IDX_TIMER_CONTROL) || (regIndex == IDX_COUNTER_PERIOD) ||
                    (regIndex == IDX_HIGH_WIDTH) || (regIndex == IDX_ENVELOPE_CONTROL) ||
                    (regIndex == IDX_ENVELOPE_COUNT) || (regIndex == IDX_IR_CONTROL) ||
                    (regIndex == IDX_STATUS);

  // ----------------------------------------
  // Tick generation
  // ----------------------------------------
  ir_tick_divider u_div (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .carrierSel   (ctrl_reg.clkSel),
    .envelopeSel  (envCtrl_reg[ENV_CLK_LSB +: 2]),
    .carrierTick  (carrierTick),
    .envelopeTick (envelopeTick)
  );

  // ----------------------------------------
  // APB register writes
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_reg             <= '0;
      ctrlSpare_reg        <= 1'b0;
      periodPreload_reg    <= RESET_BYTE;
      highWidthPreload_reg <= RESET_BYTE;
      envCtrl_reg          <= RESET_BYTE;
      envPreload_reg       <= ENV_RESET;
      irCtrl_reg           <= RESET_BYTE;
    end else if (wrEn) begin
      case (regIndex)
        IDX_TIMER_CONTROL: begin
          ctrl_reg.enable <= pwdata[CTRL_ENABLE_BIT];
          ctrlSpare_reg   <= pwdata[6];
          ctrl_reg.clkSel <= pwdata[CTRL_CLK_LSB +: 2];
          ctrl_reg.mode   <= pwdata[CTRL_MODE_LSB +: 2];
        end
        IDX_COUNTER_PERIOD:   periodPreload_reg    <= pwdata[7:0];
        IDX_HIGH_WIDTH:       highWidthPreload_reg <= pwdata[7:0];
        IDX_ENVELOPE_CONTROL: envCtrl_reg          <= pwdata[7:0] & 8'hB0;
        IDX_ENVELOPE_COUNT:   envPreload_reg       <= pwdata[ENV_WIDTH-1:0];
        IDX_IR_CONTROL:       irCtrl_reg           <= pwdata[7:0] & 8'h58;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // APB read path and answer
  // ----------------------------------------
  // Read data is registered in the setup cycle so it is steady in the access phase.
  always_comb begin
    prdata_next = 32'h0000_0000;
    case (regIndex)
      IDX_TIMER_CONTROL: prdata_next[7:0] = {ctrl_reg.enable, ctrlSpare_reg,
                                             ctrl_reg.clkSel, 2'b00, ctrl_reg.mode};
      IDX_COUNTER_PERIOD:   prdata_next[7:0] = counter_reg;
      IDX_HIGH_WIDTH:       prdata_next[7:0] = highWidthPreload_reg;
      IDX_ENVELOPE_CONTROL: prdata_next[7:0] = envCtrl_reg;
      IDX_ENVELOPE_COUNT:   prdata_next[ENV_WIDTH-1:0] = envCount_reg;
      IDX_IR_CONTROL:       prdata_next[7:0] = irCtrl_reg;
      IDX_STATUS:           prdata_next[3:0] = {envGate_reg, running_reg,
                                                envFlag_reg, carrierFlag_reg};
      default:              prdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      prdata <= prdata_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      pslverr <= psel && !penable && !addrHit;
    end
  end

  // ----------------------------------------
  // Carrier counter
  // ----------------------------------------
  // Overflow is the step below zero; the wrap is replaced by a reload.
  assign carrierOverflow = running_reg && carrierTick && (counter_reg == 8'h00);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      running_reg <= 1'b0;
      counter_reg <= RESET_BYTE;
      compare_reg <= RESET_BYTE;
      carrier_reg <= 1'b0;
    end else if (!ctrl_reg.enable) begin
      running_reg <= 1'b0;
      carrier_reg <= 1'b0;
    end else if (!running_reg) begin
      running_reg <= 1'b1;
      counter_reg <= periodPreload_reg;
      compare_reg <= highWidthPreload_reg;
      carrier_reg <= 1'b0;
    end else if (carrierOverflow) begin
      counter_reg <= periodPreload_reg;
      compare_reg <= highWidthPreload_reg;
      carrier_reg <= 1'b0;
    end else if (carrierTick) begin
      counter_reg <= counter_reg - 8'h01;
      if (counter_reg - 8'h01 == compare_reg) begin
        carrier_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      carrierFlag_reg <= 1'b0;
    end else if (carrierOverflow) begin
      carrierFlag_reg <= 1'b1;
    end else if (wrEn && regIndex == IDX_STATUS && pwdata[0]) begin
      carrierFlag_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Envelope timer
  // ----------------------------------------
  assign envByCarrier = envCtrl_reg[ENV_CLK_LSB +: 2] == ENV_CLK_CARRIER;
  // Carrier as clock: count on each rising carrier edge.
  assign envStep = envRunning_reg &&
                   (envByCarrier ? (carrier_reg && !carrierPrev_reg) : envelopeTick);
  assign envOverflow = envStep && (envCount_reg == ENV_ALL_ONES);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      carrierPrev_reg <= 1'b0;
    end else begin
      carrierPrev_reg <= carrier_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      envRunning_reg <= 1'b0;
      envCount_reg   <= ENV_RESET;
    end else if (!envCtrl_reg[ENV_ENABLE_BIT]) begin
      envRunning_reg <= 1'b0;
    end else if (!envRunning_reg) begin
      envRunning_reg <= 1'b1;
      envCount_reg   <= envPreload_reg;
    end else if (envOverflow) begin
      envCount_reg   <= envPreload_reg;
    end else if (envStep) begin
      envCount_reg   <= envCount_reg + 12'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      envFlag_reg <= 1'b0;
    end else if (envOverflow) begin
      envFlag_reg <= 1'b1;
    end else if (wrEn && regIndex == IDX_STATUS && pwdata[1]) begin
      envFlag_reg <= 1'b0;
    end
  end

  // Gate starts as mark when the envelope starts and alternates per overflow.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      envGate_reg <= 1'b0;
    end else if (!envRunning_reg) begin
      envGate_reg <= 1'b1;
    end else if (envOverflow) begin
      envGate_reg <= !envGate_reg;
    end
  end

  // ----------------------------------------
  // Transmit pin
  // ----------------------------------------
  assign gateOn = envByCarrier ? (envRunning_reg && envGate_reg) : 1'b1;

  always_comb begin
    pin_next = 1'b0;
    if (irCtrl_reg[IR_DISABLE_BIT]) begin
      pin_next = 1'b0;
    end else if (!ctrl_reg.enable) begin
      pin_next = 1'b0;
    end else if (ctrl_reg.mode == WITHOUT_CARRIER_CODE) begin
      pin_next = gateOn;
    end else if (ctrl_reg.mode == WITH_CARRIER_CODE) begin
      pin_next = gateOn && carrier_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irTransmitPin         <= 1'b0;
      irDriveCurrent        <= 2'b00;
      carrierOverflowEvent  <= 1'b0;
      envelopeOverflowEvent <= 1'b0;
    end else begin
      irTransmitPin         <= pin_next;
      irDriveCurrent        <= irCtrl_reg[DRIVE_LSB +: 2];
      carrierOverflowEvent  <= carrierOverflow;
      envelopeOverflowEvent <= envOverflow;
    end
  end

endmodule
`default_nettype wire

// ===== ir_carrier_pkg.sv
// Purpose: Shared constants and types for the IR carrier PWM timer.
// Assumes: APB slave with 32-bit data; printed offsets are register indices.
// Notes:   Byte address of a register is four times its index.
package ir_carrier_pkg;

  // ----------------------------------------
  // Register indices and address width
  // ----------------------------------------
  localparam logic [7:0]  IDX_TIMER_CONTROL    = 8'h21;
  localparam logic [7:0]  IDX_COUNTER_PERIOD   = 8'h23;
  localparam logic [7:0]  IDX_HIGH_WIDTH       = 8'h24;
  localparam logic [7:0]  IDX_ENVELOPE_CONTROL = 8'h30;
  localparam logic [7:0]  IDX_ENVELOPE_COUNT   = 8'h31;
  localparam logic [7:0]  IDX_IR_CONTROL       = 8'h32;
  localparam logic [7:0]  IDX_STATUS           = 8'h33;
  localparam int          ADDR_W               = 10;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int          CTRL_ENABLE_BIT      = 7;
  localparam int          CTRL_CLK_LSB         = 4;
  localparam int          CTRL_MODE_LSB        = 0;
  localparam logic [7:0]  CTRL_WRITE_MASK      = 8'hF3;
  localparam int          ENV_ENABLE_BIT       = 7;
  localparam int          ENV_CLK_LSB          = 4;
  localparam int          IR_DISABLE_BIT       = 6;
  localparam int          DRIVE_LSB            = 3;
  localparam int          ENV_WIDTH            = 12;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [7:0]  RESET_BYTE           = 8'h00;
  localparam logic [11:0] ENV_RESET            = 12'h000;
  localparam logic [11:0] ENV_ALL_ONES         = 12'hFFF;
  localparam logic [1:0]  WITH_CARRIER_CODE    = 2'b00;
  localparam logic [1:0]  WITHOUT_CARRIER_CODE = 2'b01;
  localparam logic [1:0]  ENV_CLK_CARRIER      = 2'b11;
  localparam logic [3:0]  DIV2_MASK            = 4'h1;
  localparam logic [3:0]  DIV4_MASK            = 4'h3;
  localparam logic [3:0]  DIV16_MASK           = 4'hF;
  localparam logic [5:0]  DIV64_MASK           = 6'h3F;

  typedef struct packed {
    logic       enable;
    logic [1:0] clkSel;
    logic [1:0] mode;
  } carrier_ctrl_s;

endpackage

// ===== ir_tick_divider.sv
// Purpose: Free-running divider giving one-cycle count enables.
// Assumes: Single system clock, synchronous reset.
// Notes:   No derived clocks; every output is a sysClk-wide pulse.
`timescale 1ns/1ps
`default_nettype none
module ir_tick_divider
  import ir_carrier_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [1:0] carrierSel,
  input  wire logic [1:0] envelopeSel,
  output logic            carrierTick,
  output logic            envelopeTick
);

  logic [5:0] divCnt_reg;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      divCnt_reg <= 6'h00;
    end else begin
      divCnt_reg <= divCnt_reg + 6'h01;
    end
  end

  always_comb begin
    case (carrierSel)
      2'b00:   carrierTick = 1'b1;
      2'b01:   carrierTick = (divCnt_reg[3:0] & DIV2_MASK) == 4'h0;
      2'b10:   carrierTick = (divCnt_reg[3:0] & DIV4_MASK) == 4'h0;
      default: carrierTick = (divCnt_reg[3:0] & DIV16_MASK) == 4'h0;
    endcase
    case (envelopeSel)
      2'b00:   envelopeTick = 1'b1;
      2'b01:   envelopeTick = (divCnt_reg[3:0] & DIV4_MASK) == 4'h0;
      2'b10:   envelopeTick = (divCnt_reg & DIV64_MASK) == 6'h00;
      default: envelopeTick = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ===== ir_carrier_pwm_timer_sva.sv
// Purpose: Port checker for the IR carrier PWM timer.
// Assumes: High width is always programmed below the period.
// Notes:   Shadow flops mirror bus writes so each check knows the mode.
`timescale 1ns/1ps
`default_nettype none
module ir_carrier_pwm_timer_sva
  import ir_carrier_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              srst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              irTransmitPin,
  input wire logic [1:0]        irDriveCurrent,
  input wire logic              carrierOverflowEvent,
  input wire logic              envelopeOverflowEvent
);
  logic        wrAcc;
  logic        ctrlWr;
  logic        irWr;
  logic        enReg;
  logic        irOffReg;
  logic        envOnReg;
  logic [1:0]  modeReg;
  logic [12:0] gapCnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  assign wrAcc  = psel && penable && pwrite;
  assign ctrlWr = wrAcc && paddr[9:2] == IDX_TIMER_CONTROL;
  assign irWr   = wrAcc && paddr[9:2] == IDX_IR_CONTROL;
  // ----------------------------------------
  // Shadow of the settings
  // ----------------------------------------
  // The gap counter bounds the wait for an overflow, since even the slowest
  // setting must overflow within 256 ticks of divide by 16.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      enReg    <= 1'b0;
      modeReg  <= 2'b00;
      irOffReg <= 1'b0;
      envOnReg <= 1'b0;
      gapCnt   <= 13'h0000;
    end else begin
      if (ctrlWr) begin
        enReg   <= pwdata[CTRL_ENABLE_BIT];
        modeReg <= pwdata[1:0];
      end
      if (irWr) begin
        irOffReg <= pwdata[IR_DISABLE_BIT];
      end
      // The envelope gates the pin whenever its clock is the carrier, enabled or not.
      if (wrAcc && paddr[9:2] == IDX_ENVELOPE_CONTROL) begin
        envOnReg <= pwdata[ENV_CLK_LSB +: 2] == ENV_CLK_CARRIER;
      end
      gapCnt <= (carrierOverflowEvent || !enReg) ? 13'h0000 : gapCnt + 13'h0001;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_start_low; ctrlWr && pwdata[7] && !enReg && pwdata[1:0] == WITH_CARRIER_CODE
    |=> !irTransmitPin [*2]; endproperty
  a_start_low: assert property (p_start_low) else $error("pin not low after start");
  property p_ovf_low; carrierOverflowEvent && enReg && modeReg == WITH_CARRIER_CODE
    |-> ##[0:2] !irTransmitPin; endproperty
  a_ovf_low: assert property (p_ovf_low) else $error("pin not low at overflow");
  property p_ir_off; irWr && pwdata[IR_DISABLE_BIT] |-> ##2 !irTransmitPin [*4]; endproperty
  a_ir_off: assert property (p_ir_off) else $error("pin active while disabled");
  property p_static_high; ctrlWr && pwdata[7] && pwdata[1:0] == WITHOUT_CARRIER_CODE
    && !irOffReg && !envOnReg |-> ##[1:4] irTransmitPin; endproperty
  a_static_high: assert property (p_static_high) else $error("static level not high");
  property p_stop_low; ctrlWr && !pwdata[CTRL_ENABLE_BIT] |-> ##2 !irTransmitPin [*4]; endproperty
  a_stop_low: assert property (p_stop_low) else $error("pin not low after stop");
  property p_drive; irWr |-> ##2 irDriveCurrent == $past(pwdata[DRIVE_LSB +: 2], 2); endproperty
  a_drive: assert property (p_drive) else $error("drive field not taken");
  property p_reserved; psel && penable && !pwrite && paddr[9:2] == IDX_TIMER_CONTROL
    |-> prdata[31:8] == 24'h00_0000 && prdata[3:2] == 2'b00; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");
  property p_running; enReg |-> gapCnt < 13'h1068; endproperty
  a_running: assert property (p_running) else $error("counter stopped overflowing");
endmodule
bind ir_carrier_pwm_timer ir_carrier_pwm_timer_sva u_ir_carrier_pwm_timer_sva (
  .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irTransmitPin(irTransmitPin), .irDriveCurrent(irDriveCurrent),
  .carrierOverflowEvent(carrierOverflowEvent), .envelopeOverflowEvent(envelopeOverflowEvent));
`default_nettype wire

// ===== ir_led_model.sv
// Purpose: Infrared LED driver seen from the transmit pin.
// Assumes: The LED follows the pin level with no delay.
// Notes:   Counts light pulses and lit cycles between clears.
`timescale 1ns/1ps
`default_nettype none
module ir_led_model (
  input  wire logic sys_clk,
  input  wire logic clearCnt,
  input  wire logic pinLevel,
  output int        pulseCnt,
  output int        litCycles
);
  logic lastLevel = 1'b0;
  always @(posedge sys_clk) begin
    lastLevel <= pinLevel;
    if (clearCnt) begin
      pulseCnt  <= 0;
      litCycles <= 0;
    end else begin
      pulseCnt  <= pulseCnt + int'(pinLevel && !lastLevel);
      litCycles <= litCycles + int'(pinLevel);
    end
  end
endmodule
`default_nettype wire

// ===== ir_carrier_pwm_timer_test.sv
// Purpose: Self-checking bench for the IR carrier PWM timer.
// Assumes: Pready answers within 64 cycles.
// Notes:   Waveforms are judged over whole periods, so divider phase cannot skew counts.
`timescale 1ns/1ps
`default_nettype none
module ir_carrier_pwm_timer_test;
  import ir_carrier_pkg::*;
  typedef struct packed {logic [7:0] ctrl; logic [7:0] period; logic [7:0] width;} row_s;
  logic              sys_clk = 1'b0, srst = 1'b1, clearCnt = 1'b0, err;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic              pready, pslverr, irTransmitPin, cOvf, eOvf;
  logic [1:0]        irDriveCurrent;
  logic [7:0]        regIdx [3] = '{IDX_TIMER_CONTROL, IDX_COUNTER_PERIOD, IDX_HIGH_WIDTH};
  int                pulseCnt, litCycles, div, win, ovf, hi, pul, error_cnt = 0, tests_run = 0;
  row_s              rows [6] = '{'{8'h80, 8'h03, 8'h01}, '{8'h90, 8'h05, 8'h02},
    '{8'hA0, 8'h0F, 8'h08}, '{8'hB0, 8'h02, 8'h01}, '{8'h80, 8'hFF, 8'hFE}, '{8'h81, 8'h03, 8'h00}};
  always #5 sys_clk = ~sys_clk;
  ir_carrier_pwm_timer u_ir_carrier_pwm_timer (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irTransmitPin(irTransmitPin),
    .irDriveCurrent(irDriveCurrent), .carrierOverflowEvent(cOvf), .envelopeOverflowEvent(eOvf));
  ir_led_model u_ir_led_model (.sys_clk(sys_clk), .clearCnt(clearCnt), .pinLevel(irTransmitPin),
    .pulseCnt(pulseCnt), .litCycles(litCycles));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("mismatches %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'(pready));
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // The model clears on the first edge; the next cycles edges are counted.
  task automatic measure(input int cycles);
    clearCnt <= 1'b1;
    @(posedge sys_clk);
    clearCnt <= 1'b0;
    ovf = 0;
    repeat (cycles) begin
      @(posedge sys_clk);
      ovf += int'(cOvf);
    end
    @(negedge sys_clk);
    hi = litCycles;
    pul = pulseCnt;
    @(posedge sys_clk);
  endtask
  task automatic env_gap();
    int n = 0;
    ovf = 0;
    hi = 0;
    do begin
      @(posedge sys_clk);
      n++;
      ovf += int'(cOvf);
      hi += (n > 3) ? int'(irTransmitPin) : 0;
    end while (eOvf !== 1'b1 && n < 400);
    if (eOvf !== 1'b1) begin
      chk("envelopeEvent", 32'h1, 32'(eOvf));
      end_of_test();
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      div = (rows[i].ctrl[5:4] == 2'b00) ? 1 : (rows[i].ctrl[5:4] == 2'b01) ? 2 :
            (rows[i].ctrl[5:4] == 2'b10) ? 4 : 16;
      win = 4 * (int'(rows[i].period) + 1) * div;
      apb(1'b1, IDX_COUNTER_PERIOD, 32'(rows[i].period));
      apb(1'b1, IDX_HIGH_WIDTH, 32'(rows[i].width));
      apb(1'b1, IDX_TIMER_CONTROL, 32'(rows[i].ctrl));
      repeat (win / 2) @(posedge sys_clk);
      measure(win);
      if (rows[i].ctrl[1:0] == WITHOUT_CARRIER_CODE) begin
        chk("litCycles", 32'(win), 32'(hi));
        chk("pulses", 32'h0, 32'(pul));
      end else begin
        chk("litCycles", 32'(4 * (int'(rows[i].width) + 1) * div), 32'(hi));
        chk("pulses", 32'h4, 32'(pul));
      end
      chk("overflows", 32'h4, 32'(ovf));
      apb(1'b1, IDX_TIMER_CONTROL, 32'h0000_0000);
      repeat (4) @(posedge sys_clk);
      chk("pinStopped", 32'h0, 32'(irTransmitPin));
    end
    apb(1'b1, IDX_HIGH_WIDTH, 32'h0000_005A);
    apb(1'b0, IDX_HIGH_WIDTH, 32'h0000_0000);
    chk("widthRead", 32'h0000_005A, rd);
    srst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    foreach (regIdx[k]) begin
      apb(1'b0, regIdx[k], 32'h0000_0000);
      chk("resetValue", 32'(RESET_BYTE), rd);
    end
    apb(1'b1, IDX_COUNTER_PERIOD, 32'h0000_0077);
    apb(1'b0, IDX_COUNTER_PERIOD, 32'h0000_0000);
    chk("liveCount", 32'h0000_0000, rd);
    apb(1'b1, IDX_TIMER_CONTROL, 32'h0000_00FF);
    apb(1'b0, IDX_TIMER_CONTROL, 32'h0000_0000);
    chk("ctrlMask", 32'(CTRL_WRITE_MASK), rd);
    apb(1'b1, IDX_TIMER_CONTROL, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmappedData", 32'h0000_0000, rd);
    chk("unmappedErr", 32'h1, 32'(err));
    apb(1'b1, IDX_IR_CONTROL, 32'h0000_0018);
    // The drive output is registered once more after the register, so look mid-cycle.
    @(negedge sys_clk);
    chk("drive", 32'h3, 32'(irDriveCurrent));
    @(posedge sys_clk);
    apb(1'b1, IDX_COUNTER_PERIOD, 32'h0000_0003);
    apb(1'b1, IDX_HIGH_WIDTH, 32'h0000_0001);
    apb(1'b1, IDX_TIMER_CONTROL, 32'h0000_0080);
    apb(1'b1, IDX_IR_CONTROL, 32'h0000_0040);
    measure(16);
    chk("litDisabled", 32'h0, 32'(hi));
    chk("driveCleared", 32'h0, 32'(irDriveCurrent));
    apb(1'b1, IDX_IR_CONTROL, 32'h0000_0000);
    apb(1'b1, IDX_ENVELOPE_COUNT, 32'h0000_0FFC);
    apb(1'b1, IDX_ENVELOPE_CONTROL, 32'h0000_00B0);
    env_gap();
    env_gap();
    chk("spaceLit", 32'h0, 32'(hi));
    chk("envelopeSpan", 32'h4, 32'(ovf));
    env_gap();
    chk("markLit", 32'h1, 32'(hi > 0));
    apb(1'b1, IDX_ENVELOPE_CONTROL, 32'h0000_0000);
    apb(1'b1, IDX_TIMER_CONTROL, 32'h0000_0000);
    end_of_test();
  end
endmodule
`default_nettype wire
